//--- ppa_top.v
// Parallel peripheral adapter: two 8-bit ports, control lines, AXI4-Lite registers
// Overview of operation
// RL1: Host reaches adapter only through memory reads/writes
// RL2: Control bit 2 selects data or direction
// RL3: Host sets select bit before port access
// RL4: Control bits 6,7 are read-only status flags
// RL5: Reading control register clears its flags
// RL6: Four interrupt lines, two usable as controls
// RL7: Direction bit one drives output, zero input
// RL8: Port read mixes pins and output latch
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ppa_regs.vh"
module ppa_top (
  // Clock, reset, enable
  input  wire                   REF_CLK,
  input  wire                   RST,
  input  wire                   CE,
  // AXI4-Lite write address
  input  wire [`PPA_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire [2:0]             S_AXI_AWPROT,
  input  wire                   S_AXI_AWVALID,
  output reg                    S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire [31:0]            S_AXI_WDATA,
  input  wire [3:0]             S_AXI_WSTRB,
  input  wire                   S_AXI_WVALID,
  output reg                    S_AXI_WREADY,
  // AXI4-Lite write response
  output reg  [1:0]             S_AXI_BRESP,
  output reg                    S_AXI_BVALID,
  input  wire                   S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire [`PPA_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire [2:0]             S_AXI_ARPROT,
  input  wire                   S_AXI_ARVALID,
  output reg                    S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg  [31:0]            S_AXI_RDATA,
  output reg  [1:0]             S_AXI_RRESP,
  output reg                    S_AXI_RVALID,
  input  wire                   S_AXI_RREADY,
  // Port A lines
  input  wire [7:0]             PORT_A_LINES_I,
  output wire [7:0]             PORT_A_LINES_O,
  output wire [7:0]             PORT_A_LINES_OE,
  // Port B lines
  input  wire [7:0]             PORT_B_LINES_I,
  output wire [7:0]             PORT_B_LINES_O,
  output wire [7:0]             PORT_B_LINES_OE,
  // Interrupt input lines
  input  wire                   SIDE_A_INT_LINE,
  input  wire                   SIDE_B_INT_LINE,
  // Auxiliary control lines, two-way
  input  wire                   SIDE_A_AUX_CONTROL_LINE_I,
  output reg                    SIDE_A_AUX_CONTROL_LINE_O,
  output reg                    SIDE_A_AUX_CONTROL_LINE_OE,
  input  wire                   SIDE_B_AUX_CONTROL_LINE_I,
  output reg                    SIDE_B_AUX_CONTROL_LINE_O,
  output reg                    SIDE_B_AUX_CONTROL_LINE_OE,
  // Interrupt request
  output reg                    IRQ
);

  // Per-port state
  reg  [7:0]  cr   [0:`PPA_PORTS-1];
  reg  [7:0]  ddr  [0:`PPA_PORTS-1];
  reg  [7:0]  outl [0:`PPA_PORTS-1];
  reg  [3:0]  irq_stat;
  reg  [3:0]  irq_mask;

  // Bus slave state
  reg  [2:0]  aw_idx;
  reg         aw_hit;
  reg         aw_got;
  reg  [7:0]  wd;
  reg         wd_lane0;
  reg  [3:0]  wd_w1c;
  reg         w_got;

  // Synchronised inputs and edge history
  wire [19:0] pins_q;
  wire [7:0]  pin_in [0:`PPA_PORTS-1];
  wire [1:0]  c1_q;
  wire [1:0]  c2_q;
  reg  [1:0]  c1_prev;
  reg  [1:0]  c2_prev;
  wire [1:0]  act1;
  wire [1:0]  act2;
  wire [3:0]  irq_set;

  // Read decode
  reg  [7:0]  rd_byte;
  reg         rd_err;
  reg  [1:0]  rd_clr;
  wire        ar_hs;
  wire        do_write;
  integer     i;
  genvar      g;

  // Every pin from outside crosses two flops before any logic sees it
  ppa_sync #(
    .WIDTH (20)
  ) u_sync (
    .clk (REF_CLK),
    .rst (RST),
    .ce  (CE),
    .d   ({SIDE_B_AUX_CONTROL_LINE_I, SIDE_A_AUX_CONTROL_LINE_I,
           SIDE_B_INT_LINE, SIDE_A_INT_LINE, PORT_B_LINES_I, PORT_A_LINES_I}),
    .q   (pins_q)
  );

  assign pin_in[0] = pins_q[7:0];
  assign pin_in[1] = pins_q[15:8];
  assign c1_q      = pins_q[17:16];
  assign c2_q      = pins_q[19:18];

  // Edge history is taken from the second synchroniser stage only, so a
  // metastable first stage can never reach a flag
  // Active transition per line; the edge sense comes from the control register
  generate
    for (g = 0; g < `PPA_PORTS; g = g + 1) begin : g_edge
      assign act1[g] = cr[g][`PPA_CR_C1_RISE] ? (c1_q[g] & ~c1_prev[g])
                                               : (~c1_q[g] & c1_prev[g]); // [RL6]
      // An aux line set as output raises no flag
      assign act2[g] = ~cr[g][`PPA_CR_C2_OUT] &
                       (cr[g][`PPA_CR_C2_RISE] ? (c2_q[g] & ~c2_prev[g])
                                               : (~c2_q[g] & c2_prev[g])); // [RL6]
    end
  endgenerate

  // Enables gate only the status word; the control-register flags record
  // every active edge, so software that polls still sees it
  // Sticky status only for lines whose interrupt is enabled
  assign irq_set = {act2[1] & cr[1][`PPA_CR_C2_EN_LVL], act1[1] & cr[1][`PPA_CR_C1_EN],
                    act2[0] & cr[0][`PPA_CR_C2_EN_LVL], act1[0] & cr[0][`PPA_CR_C1_EN]};

  // Handshake strobes; protection inputs and upper data lanes carry nothing here
  assign ar_hs    = S_AXI_ARVALID & S_AXI_ARREADY;
  assign do_write = aw_got & w_got & ~S_AXI_BVALID;

  // Ports drive from the output latch where the direction bit is one
  assign PORT_A_LINES_O  = outl[0];
  assign PORT_A_LINES_OE = ddr[0]; // [RL7]
  assign PORT_B_LINES_O  = outl[1];
  assign PORT_B_LINES_OE = ddr[1]; // [RL7]

  // Read mux, decoded straight from the presented address
  // Decoding before the handshake lets the flags clear on the very edge at
  // which the host takes them, so a second read already sees them cleared
  always @* begin
    rd_byte = 8'h00;
    rd_err  = 1'b0;
    rd_clr  = 2'h0;
    case (S_AXI_ARADDR[4:2])
      `PPA_IDX_PORT_A, `PPA_IDX_PORT_B: begin
        // Select bit picks data or direction; host must set it first [RL2] [RL3]
        if (cr[S_AXI_ARADDR[3]][`PPA_CR_SEL_DATA]) begin
          rd_byte = (pin_in[S_AXI_ARADDR[3]] & ~ddr[S_AXI_ARADDR[3]]) |
                    (outl[S_AXI_ARADDR[3]] & ddr[S_AXI_ARADDR[3]]); // [RL8]
        end else begin
          rd_byte = ddr[S_AXI_ARADDR[3]];
        end
      end
      `PPA_IDX_CTRL_A, `PPA_IDX_CTRL_B: begin
        rd_byte = cr[S_AXI_ARADDR[3]]; // [RL4]
        rd_clr[S_AXI_ARADDR[3]] = 1'b1; // [RL5]
      end
      `PPA_IDX_IRQ_STAT: begin
        rd_byte = {4'h0, irq_stat};
      end
      `PPA_IDX_IRQ_MASK: begin
        rd_byte = {4'h0, irq_mask};
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // AXI4-Lite handshakes: one write and one read in flight at most [RL1]
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `PPA_RESP_OKAY;
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RRESP   <= `PPA_RESP_OKAY;
      S_AXI_RDATA   <= 32'h00000000;
      aw_idx        <= 3'h0;
      aw_hit        <= 1'b0;
      aw_got        <= 1'b0;
      wd            <= 8'h00;
      wd_lane0      <= 1'b0;
      wd_w1c        <= 4'h0;
      w_got         <= 1'b0;
    end else if (CE) begin
      // Readies rest high; a master must not run while CE is low, since a
      // frozen block would let that handshake slip by unrecorded
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_idx        <= S_AXI_AWADDR[4:2];
        aw_hit        <= (S_AXI_AWADDR[4:2] <= `PPA_IDX_IRQ_MASK);
        aw_got        <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wd           <= S_AXI_WDATA[7:0];
        wd_lane0     <= S_AXI_WSTRB[0];
        wd_w1c       <= S_AXI_WSTRB[0] ? S_AXI_WDATA[3:0] : 4'h0;
        w_got        <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= aw_hit ? `PPA_RESP_OKAY : `PPA_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        // Address and data re-open only after the response is taken
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
      if (ar_hs) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= {24'h000000, rd_byte};
        S_AXI_RRESP   <= rd_err ? `PPA_RESP_SLVERR : `PPA_RESP_OKAY;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // Register file, flags and interrupt status
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (i = 0; i < `PPA_PORTS; i = i + 1) begin
        cr[i]   <= `PPA_CR_RST;
        ddr[i]  <= `PPA_DDR_RST;
        outl[i] <= `PPA_OUT_RST;
      end
      c1_prev  <= 2'h0;
      c2_prev  <= 2'h0;
      irq_stat <= `PPA_IRQ_RST;
      irq_mask <= `PPA_IRQ_RST;
    end else if (CE) begin
      c1_prev <= c1_q;
      c2_prev <= c2_q;
      // A transition in the same cycle as the clearing read still sets the flag
      for (i = 0; i < `PPA_PORTS; i = i + 1) begin
        cr[i][`PPA_CR_FLAG1] <= (cr[i][`PPA_CR_FLAG1] & ~(ar_hs & rd_clr[i])) | act1[i]; // [RL5]
        cr[i][`PPA_CR_FLAG2] <= (cr[i][`PPA_CR_FLAG2] & ~(ar_hs & rd_clr[i])) | act2[i]; // [RL5]
      end
      // Write-one-to-clear; a new event wins over the clear
      irq_stat <= (irq_stat & ~((do_write && aw_idx == `PPA_IDX_IRQ_STAT) ? wd_w1c : 4'h0))
                  | irq_set;
      // Only byte lane 0 carries register data; a write without it does nothing
      if (do_write && wd_lane0) begin
        case (aw_idx)
          `PPA_IDX_PORT_A, `PPA_IDX_PORT_B: begin
            // Data writes land in the latch only; input bits keep reading the pins
            if (cr[aw_idx[1]][`PPA_CR_SEL_DATA]) begin
              outl[aw_idx[1]] <= wd; // [RL2] [RL8]
            end else begin
              ddr[aw_idx[1]] <= wd; // [RL2] [RL7]
            end
          end
          `PPA_IDX_CTRL_A, `PPA_IDX_CTRL_B: begin
            cr[aw_idx[1]][5:0] <= wd[5:0]; // [RL4]
          end
          `PPA_IDX_IRQ_MASK: begin
            irq_mask <= wd[3:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Aux lines and interrupt output, registered so every output leaves a flop
  // The aux level follows control bit 3 one cycle late, which keeps decode
  // glitches off the pin at the cost of one cycle of latency
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SIDE_A_AUX_CONTROL_LINE_O  <= 1'b0;
      SIDE_A_AUX_CONTROL_LINE_OE <= 1'b0;
      SIDE_B_AUX_CONTROL_LINE_O  <= 1'b0;
      SIDE_B_AUX_CONTROL_LINE_OE <= 1'b0;
      IRQ                        <= 1'b0;
    end else if (CE) begin
      SIDE_A_AUX_CONTROL_LINE_O  <= cr[0][`PPA_CR_C2_EN_LVL]; // [RL6]
      SIDE_A_AUX_CONTROL_LINE_OE <= cr[0][`PPA_CR_C2_OUT]; // [RL6]
      SIDE_B_AUX_CONTROL_LINE_O  <= cr[1][`PPA_CR_C2_EN_LVL]; // [RL6]
      SIDE_B_AUX_CONTROL_LINE_OE <= cr[1][`PPA_CR_C2_OUT]; // [RL6]
      IRQ                        <= |(irq_stat & irq_mask);
    end
  end

endmodule

//--- ppa_regs.vh
// Register offsets, field positions and reset values of the parallel peripheral adapter
`ifndef PPA_REGS_VH
`define PPA_REGS_VH

// Bus geometry
`define PPA_ADDR_W        5
`define PPA_PORTS         2

// Register word indices (byte address = index * 4)
`define PPA_IDX_PORT_A    3'h0
`define PPA_IDX_CTRL_A    3'h1
`define PPA_IDX_PORT_B    3'h2
`define PPA_IDX_CTRL_B    3'h3
`define PPA_IDX_IRQ_STAT  3'h4
`define PPA_IDX_IRQ_MASK  3'h5

// Control register fields
`define PPA_CR_C1_EN      0
`define PPA_CR_C1_RISE    1
`define PPA_CR_SEL_DATA   2
`define PPA_CR_C2_EN_LVL  3
`define PPA_CR_C2_RISE    4
`define PPA_CR_C2_OUT     5
`define PPA_CR_FLAG2      6
`define PPA_CR_FLAG1      7

// Interrupt status and mask fields
`define PPA_IRQ_A1        0
`define PPA_IRQ_A2        1
`define PPA_IRQ_B1        2
`define PPA_IRQ_B2        3

// Reset values
`define PPA_CR_RST        8'h00
`define PPA_DDR_RST       8'h00
`define PPA_OUT_RST       8'h00
`define PPA_IRQ_RST       4'h0

// Bus responses
`define PPA_RESP_OKAY     2'h0
`define PPA_RESP_SLVERR   2'h2

`endif

//--- ppa_sync.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ppa_sync #(
  parameter WIDTH = 1
) (
  // Clock and control
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  // Data
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta;

  // First stage feeds only the second; nothing else may look at it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= {WIDTH{1'b0}};
      q    <= {WIDTH{1'b0}};
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

//--- ppa_pin_model.sv
// Peripheral-side model of the adapter's pins
`timescale 1ns/1ps
module ppa_pin_model #(
  parameter W = 9
) (
  // Adapter side
  input  wire [W-1:0] o,
  input  wire [W-1:0] oe,
  // Peripheral side
  input  wire [W-1:0] drv,
  output wire [W-1:0] lvl
);
  // Adapter drive wins on its output bits; the peripheral holds the rest
  assign lvl = (o & oe) | (drv & ~oe);
endmodule

//--- ppa_props.sv
// Bus and pin timing checks for the adapter top
`timescale 1ns/1ps
module ppa_props (
  // Clock and reset
  input wire        REF_CLK,
  input wire        RST,
  // Bus handshake
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire        S_AXI_WVALID,
  input wire        S_AXI_WREADY,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0]  S_AXI_RRESP,
  // Pins
  input wire [7:0]  PORT_A_LINES_O,
  input wire [7:0]  PORT_A_LINES_OE,
  input wire        SIDE_B_AUX_CONTROL_LINE_OE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Write answered two edges after address and data are taken together
  property p_wr_ans;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_wr_busy;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write accepted while busy");
  property p_b_done;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write not closed");
  property p_rd_ans;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_rd_done;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read not closed");
  // Refused reads carry no data; only the low byte is ever live
  property p_rd_data;
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0 && (S_AXI_RRESP != 2'h2 || S_AXI_RDATA == 32'h0);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("bad read data");
  // Pin drive changes only as the result of a register write
  property p_dir_chg;
    $changed(PORT_A_LINES_OE) |-> S_AXI_BVALID;
  endproperty
  a_dir_chg: assert property (p_dir_chg) else $error("direction moved alone");
  property p_out_chg;
    $changed(PORT_A_LINES_O) |-> S_AXI_BVALID;
  endproperty
  a_out_chg: assert property (p_out_chg) else $error("output latch moved alone");
  property p_aux_chg;
    $changed(SIDE_B_AUX_CONTROL_LINE_OE) |-> $past(S_AXI_BVALID);
  endproperty
  a_aux_chg: assert property (p_aux_chg) else $error("aux direction moved alone");
endmodule

bind ppa_top ppa_props ppa_props_i (
  .REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .PORT_A_LINES_O(PORT_A_LINES_O), .PORT_A_LINES_OE(PORT_A_LINES_OE),
  .SIDE_B_AUX_CONTROL_LINE_OE(SIDE_B_AUX_CONTROL_LINE_OE));

//--- ppa_tb_top.sv
// Self-checking bench: register traffic and pin stimulus for the adapter
`timescale 1ns/1ps
module ppa_tb_top;
  reg         ref_clk, rst, awv, wv, bready, arv, rready, ia, ib;
  reg  [4:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [8:0]  xa, xb;
  wire [31:0] rdata;
  wire [1:0]  bresp, rresp;
  wire        awr, wrdy, bv, arr, rv, irq, xa_o, xa_oe, xb_o, xb_oe;
  wire [7:0]  pa_o, pa_oe, pb_o, pb_oe;
  wire [8:0]  la, lb;
  integer     miscompares, check_count, cyc;

  ppa_top ppa_top_i (.REF_CLK(ref_clk), .RST(rst), .CE(1'h1),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .PORT_A_LINES_I(la[7:0]), .PORT_A_LINES_O(pa_o), .PORT_A_LINES_OE(pa_oe),
    .PORT_B_LINES_I(lb[7:0]), .PORT_B_LINES_O(pb_o), .PORT_B_LINES_OE(pb_oe),
    .SIDE_A_INT_LINE(ia), .SIDE_B_INT_LINE(ib),
    .SIDE_A_AUX_CONTROL_LINE_I(la[8]), .SIDE_A_AUX_CONTROL_LINE_O(xa_o),
    .SIDE_A_AUX_CONTROL_LINE_OE(xa_oe), .SIDE_B_AUX_CONTROL_LINE_I(lb[8]),
    .SIDE_B_AUX_CONTROL_LINE_O(xb_o), .SIDE_B_AUX_CONTROL_LINE_OE(xb_oe), .IRQ(irq));
  ppa_pin_model ppa_pin_model_a (.o({xa_o, pa_o}), .oe({xa_oe, pa_oe}), .drv(xa), .lvl(la));
  ppa_pin_model ppa_pin_model_b (.o({xb_o, pb_o}), .oe({xb_oe, pb_oe}), .drv(xb), .lvl(lb));

  // Free-running clock, 5 ns period
  always #2.5 ref_clk = ~ref_clk;

  task chk(input string nm, input [31:0] e, input [31:0] g);
    check_count = check_count + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One write; address and data offered together, each released when taken
  task automatic wr(input [4:0] a, input [7:0] d, input [1:0] er);
    @(posedge ref_clk);
    awaddr <= a;
    wdata  <= {24'h0, d};
    awv    <= 1'h1;
    wv     <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge ref_clk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wrdy) wv <= 1'h0;
      if (bv) begin
        bready <= 1'h0;
        chk("write resp", er, bresp);
        break;
      end
    end
  endtask

  // One read, compared byte and response
  task automatic rd(input [4:0] a, input [7:0] e, input [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    arv    <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge ref_clk);
      if (arv && arr) arv <= 1'h0;
      if (rv) begin
        rready <= 1'h0;
        chk("read data", {24'h0, e}, rdata);
        chk("read resp", er, rresp);
        break;
      end
    end
  endtask

  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end

  initial begin
    {ref_clk, awv, wv, bready, arv, rready, ia, ib} = 8'h00;
    {awaddr, araddr, wdata} = 42'h0;
    xa = 9'h03c;
    xb = 9'h000;
    rst = 1'h1;
    {miscompares, check_count, cyc} = 96'h0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    rd(5'h04, 8'h00, 2'h0);
    rd(5'h00, 8'h00, 2'h0);
    wr(5'h00, 8'h0f, 2'h0);
    chk("direction a", 8'h0f, pa_oe);
    rd(5'h00, 8'h0f, 2'h0);
    wr(5'h04, 8'hc4, 2'h0);
    rd(5'h04, 8'h04, 2'h0);
    wr(5'h00, 8'ha5, 2'h0);
    chk("latch a", 8'ha5, pa_o);
    rd(5'h00, 8'h35, 2'h0);
    rd(5'h18, 8'h00, 2'h2);
    wr(5'h1c, 8'hff, 2'h2);
    wr(5'h14, 8'h0f, 2'h0);
    wr(5'h04, 8'h1f, 2'h0);
    ia <= 1'h1;
    xa[8] <= 1'h1;
    repeat (8) @(posedge ref_clk);
    chk("irq set", 1'h1, irq);
    chk("aux a drive", 2'h1, {xa_oe, xa_o});
    rd(5'h10, 8'h03, 2'h0);
    rd(5'h04, 8'hdf, 2'h0);
    rd(5'h04, 8'h1f, 2'h0);
    wr(5'h10, 8'h03, 2'h0);
    rd(5'h10, 8'h00, 2'h0);
    wr(5'h14, 8'h00, 2'h0);
    chk("irq cleared", 1'h0, irq);
    ia <= 1'h0;
    repeat (4) @(posedge ref_clk);
    ia <= 1'h1;
    repeat (8) @(posedge ref_clk);
    chk("irq masked", 1'h0, irq);
    wr(5'h0c, 8'h2b, 2'h0);
    ib <= 1'h1;
    repeat (8) @(posedge ref_clk);
    chk("aux b drive", 2'h3, {xb_oe, xb_o});
    rd(5'h0c, 8'hab, 2'h0);
    wr(5'h08, 8'hf0, 2'h0);
    chk("direction b", 8'hf0, pb_oe);
    chk("latch b", 8'h00, pb_o);
    rd(5'h08, 8'hf0, 2'h0);
    rd(5'h10, 8'h05, 2'h0);
    give_verdict;
  end
endmodule
